// File: flash_host_regs.vh
// Purpose: constants of the flash host controller
// Assumes: 16-bit flash data, 22-bit word address, 20 MHz clock
// Notes: byte offsets are those of the controller's own AXI4-Lite registers
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

`define CLK_MHZ 20
`define T_ACC_NS 70
`define T_WP_NS 35
`define T_WPH_NS 20

`define OFS_CTRL 8'h00
`define OFS_ADDR 8'h04
`define OFS_DATA 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RDATA 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18

`define RST_ADDR 32'h00000000
`define RST_DATA 32'h00000000
`define RST_IRQ_MASK 4'h0

`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_PROT 2
`define IRQ_HANG 3

`define OP_READ 4'h1
`define OP_QUERY 4'h2
`define OP_IDENT 4'h3
`define OP_SECURE 4'h4
`define OP_RESET 4'h5
`define OP_STATUS 4'h6
`define OP_WORD_PROG 4'h7
`define OP_BUF_START 4'h8
`define OP_BUF_WORD 4'h9
`define OP_BUF_CONFIRM 4'ha
`define OP_SEC_EXIT 4'hb

`define A_UNLOCK1 22'h000555
`define A_UNLOCK2 22'h0002aa
`define A_QUERY 22'h000055
`define A_ANY 22'h000000

`define D_UNLOCK1 16'h00aa
`define D_UNLOCK2 16'h0055
`define D_RESET 16'h00f0
`define D_STATUS 16'h0070
`define D_QUERY 16'h0098
`define D_IDENT 16'h0090
`define D_SECURE 16'h0088
`define D_WORD_PROG 16'h00a0
`define D_BUF_ENTER 16'h0025
`define D_BUF_CONFIRM 16'h0029
`define D_EXIT_ENTRY 16'h0090
`define D_EXIT 16'h0000

`define SR_READY_BIT 7
`define SR_PGM_ERR_BIT 4
`define SR_PROT_BIT 2

`define SECT_LSB 15
`define MAX_BUF_WORDS 32'd128
`define WC_DONE 8'hff

`endif

// File: flash_cycle.v
// Purpose: one asynchronous flash bus cycle, read or write
// Assumes: go is taken only while busy is low
// Notes: read data passes a three-stage synchroniser before capture
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_cycle (
  input wire i_clk,
  input wire i_rst,
  input wire i_go,
  input wire i_rd,
  input wire [21:0] i_addr,
  input wire [15:0] i_wdata,
  output wire o_busy,
  output reg o_done,
  output reg [15:0] o_rdata,
  output reg [21:0] o_fl_addr,
  output reg [15:0] o_fl_dq,
  output reg o_fl_dq_oe,
  output reg o_fl_ce_n,
  output reg o_fl_we_n,
  output reg o_fl_oe_n,
  input wire [15:0] i_fl_dq
);
  localparam integer ACC_CYC = (`T_ACC_NS * `CLK_MHZ + 999) / 1000;
  localparam integer WP_CYC = (`T_WP_NS * `CLK_MHZ + 999) / 1000;
  localparam integer WPH_CYC = (`T_WPH_NS * `CLK_MHZ + 999) / 1000;
  localparam [3:0] RD_END = ACC_CYC[3:0] + 4'h2;
  localparam [3:0] WP_END = WP_CYC[3:0] - 4'h1;
  localparam [3:0] WPH_END = WPH_CYC[3:0] - 4'h1;
  localparam [3:0] C_IDLE = 4'h1;
  localparam [3:0] C_SETUP = 4'h2;
  localparam [3:0] C_ACT = 4'h4;
  localparam [3:0] C_HOLD = 4'h8;

  reg [3:0] st_r;
  reg [3:0] cnt_r;
  reg rd_r;
  reg [15:0] dq_s1_r;
  reg [15:0] dq_s2_r;
  reg [15:0] dq_s3_r;

  assign o_busy = (st_r != C_IDLE);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= C_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_fl_addr <= 22'h000000;
      o_fl_dq <= 16'h0000;
      o_fl_dq_oe <= 1'b0;
      o_fl_ce_n <= 1'b1;
      o_fl_we_n <= 1'b1;
      o_fl_oe_n <= 1'b1;
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
      dq_s3_r <= 16'h0000;
    end else begin
      o_done <= 1'b0;
      dq_s1_r <= i_fl_dq;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
      case (st_r)
        C_IDLE: begin
          if (i_go) begin
            o_fl_addr <= i_addr;
            o_fl_dq <= i_wdata;
            rd_r <= i_rd;
            o_fl_ce_n <= 1'b0;
            o_fl_dq_oe <= ~i_rd;
            cnt_r <= 4'h0;
            st_r <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (rd_r) begin
            o_fl_oe_n <= 1'b0;
          end else begin
            o_fl_we_n <= 1'b0;
          end
          st_r <= C_ACT;
        end
        C_ACT: begin
          if (rd_r) begin
            if (cnt_r != RD_END) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (dq_s2_r == dq_s3_r) begin
              // capture only once the last two stages agree
              o_rdata <= dq_s3_r;
              o_fl_oe_n <= 1'b1;
              cnt_r <= 4'h0;
              st_r <= C_HOLD;
            end
          end else if (cnt_r == WP_END) begin
            o_fl_we_n <= 1'b1;
            cnt_r <= 4'h0;
            st_r <= C_HOLD;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        C_HOLD: begin
          if (cnt_r == WPH_END) begin
            o_fl_ce_n <= 1'b1;
            o_fl_dq_oe <= 1'b0;
            o_done <= 1'b1;
            st_r <= C_IDLE;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end
endmodule // flash_cycle

// File: axi_lite_slave.v
// Purpose: AXI4-Lite slave front end for the controller registers
// Assumes: read data is decoded combinationally from o_rd_addr
// Notes: one write and one read in flight; responses are always OKAY
`timescale 1ns/1ps
module axi_lite_slave (
  input wire i_clk,
  input wire i_rst,
  input wire [7:0] i_awaddr,
  input wire i_awvalid,
  output wire o_awready,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  input wire i_wvalid,
  output wire o_wready,
  output reg o_bvalid,
  output wire [1:0] o_bresp,
  input wire i_bready,
  input wire [7:0] i_araddr,
  input wire i_arvalid,
  output wire o_arready,
  output reg o_rvalid,
  output reg [31:0] o_rdata,
  output wire [1:0] o_rresp,
  input wire i_rready,
  output reg o_wr,
  output reg [7:0] o_wr_addr,
  output reg [31:0] o_wr_data,
  output reg [3:0] o_wr_strb,
  output wire o_rd,
  output wire [7:0] o_rd_addr,
  input wire [31:0] i_rd_data
);
  reg aw_got_r;
  reg w_got_r;

  assign o_awready = ~aw_got_r & ~o_bvalid;
  assign o_wready = ~w_got_r & ~o_bvalid;
  assign o_bresp = 2'b00;
  assign o_rresp = 2'b00;
  assign o_arready = ~o_rvalid;
  assign o_rd = i_arvalid & ~o_rvalid;
  assign o_rd_addr = i_araddr;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      o_bvalid <= 1'b0;
      o_wr <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 32'h00000000;
      o_wr_strb <= 4'h0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
    end else begin
      o_wr <= 1'b0;
      if (i_awvalid & o_awready) begin
        aw_got_r <= 1'b1;
        o_wr_addr <= i_awaddr;
      end
      if (i_wvalid & o_wready) begin
        w_got_r <= 1'b1;
        o_wr_data <= i_wdata;
        o_wr_strb <= i_wstrb;
      end
      if (aw_got_r & w_got_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        o_wr <= 1'b1;
        o_bvalid <= 1'b1;
      end else if (o_bvalid & i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (o_rd) begin
        o_rvalid <= 1'b1;
        o_rdata <= i_rd_data;
      end else if (o_rvalid & i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end
endmodule // axi_lite_slave

// File: flash_host_ctrl.v
// Purpose: host controller that drives a parallel flash through its
//   query, identification and secure region command sequences
// Assumes: software starts one operation at a time through CTRL
// Notes: the controller mirrors the device mode and refuses sequences
//   that the device state would not accept
// Behaviour
// - query mode ends with reset, previous mode
// - identification mode ends with reset, previous mode
// - secure mode: reads, status enable, reset exit
// - unlock: aa at 555, 55 at 2aa
// - unprotected: a0 word or 25 buffer program
// - exit: 90 at 555 then 00
// - valid count and sector start buffer loading
// - count at -1, 29 starts buffer program
// - timeout hang cleared only by reset f0
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module flash_host_ctrl (
  input wire I_REF_CLK,
  input wire I_SYS_RST,
  input wire [7:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output wire O_BVALID,
  output wire [1:0] O_BRESP,
  input wire I_BREADY,
  input wire [7:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output wire O_RVALID,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  input wire I_RREADY,
  output wire [21:0] O_FL_ADDR,
  output wire [15:0] O_FL_DQ,
  output wire O_FL_DQ_OE,
  input wire [15:0] I_FL_DQ,
  output wire O_FL_CE_N,
  output wire O_FL_WE_N,
  output wire O_FL_OE_N,
  output wire O_IRQ
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_CHKW = 9'h002;
  localparam [8:0] S_CHKR = 9'h004;
  localparam [8:0] S_CMD = 9'h008;
  localparam [8:0] S_RD = 9'h010;
  localparam [8:0] S_POLLW = 9'h020;
  localparam [8:0] S_POLLR = 9'h040;
  localparam [8:0] S_HANG = 9'h080;
  localparam [8:0] S_FIN = 9'h100;
  localparam [3:0] M_READ = 4'h1;
  localparam [3:0] M_QUERY = 4'h2;
  localparam [3:0] M_IDENT = 4'h4;
  localparam [3:0] M_SECURE = 4'h8;

  wire wr;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire rd;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  wire eng_busy;
  wire eng_done;
  wire [15:0] eng_rdata;

  reg [8:0] state_r;
  reg [3:0] op_r;
  reg [3:0] mode_r;
  reg [3:0] prev_mode_r;
  reg [31:0] addr_r;
  reg [31:0] data_r;
  reg [15:0] rdata_r;
  reg [3:0] irq_stat_r;
  reg [3:0] irq_mask_r;
  reg [3:0] irq_set;
  reg issued_r;
  reg go_r;
  reg [1:0] idx_r;
  reg [2:0] n_cyc_r;
  reg need_chk_r;
  reg need_rd_r;
  reg need_poll_r;
  reg buf_active_r;
  reg [6:0] entry_sector_addr_r;
  reg [7:0] remaining_word_count_r;
  reg [21:0] seq_addr [0:3];
  reg [15:0] seq_data [0:3];
  reg req_rd;
  reg [21:0] req_addr;
  reg [15:0] req_data;
  wire ctrl_wr;
  wire start;
  wire [6:0] current_sector_addr;
  wire [21:0] fl_a;
  wire [15:0] wc_word;

  assign current_sector_addr = addr_r[21:`SECT_LSB];
  assign fl_a = addr_r[21:0];
  assign wc_word = data_r[15:0] - 16'h0001;
  assign ctrl_wr = wr & (wr_addr == `OFS_CTRL) & wr_strb[0];

  // whether the mirrored device state accepts an operation now
  function op_ok;
    input [3:0] op;
    input [3:0] mode;
    input buf_on;
    input [7:0] wc;
    input sect_eq;
    input [31:0] cnt;
    reg sec_idle;
    begin
      sec_idle = (mode == M_SECURE) & ~buf_on;
      case (op)
        `OP_READ: op_ok = 1'b1;
        `OP_QUERY: op_ok = (mode != M_QUERY);
        `OP_IDENT: op_ok = (mode == M_READ);
        `OP_SECURE: op_ok = (mode == M_READ);
        `OP_RESET: op_ok = (mode != M_READ) | buf_on;
        `OP_STATUS: op_ok = (mode == M_SECURE);
        `OP_WORD_PROG: op_ok = sec_idle;
        `OP_SEC_EXIT: op_ok = sec_idle;
        `OP_BUF_START: op_ok = sec_idle & (cnt != 32'h0) &
          (cnt <= `MAX_BUF_WORDS);
        `OP_BUF_WORD: op_ok = buf_on & ~wc[7] & sect_eq;
        `OP_BUF_CONFIRM: op_ok = buf_on & (wc == `WC_DONE) &
          sect_eq;
        default: op_ok = 1'b0;
      endcase
    end
  endfunction

  // byte-lane merge for software-writable words
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  assign start = ctrl_wr & (state_r == S_IDLE) &
    op_ok(wr_data[3:0], mode_r, buf_active_r, remaining_word_count_r,
      current_sector_addr == entry_sector_addr_r, data_r);
  assign O_IRQ = |(irq_stat_r & irq_mask_r);

  axi_lite_slave u_slave (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_awaddr(I_AWADDR),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .o_bvalid(O_BVALID),
    .o_bresp(O_BRESP),
    .i_bready(I_BREADY),
    .i_araddr(I_ARADDR),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .o_rvalid(O_RVALID),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .i_rready(I_RREADY),
    .o_wr(wr),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .o_rd(rd),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data)
  );

  flash_cycle u_cycle (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_go(go_r),
    .i_rd(req_rd),
    .i_addr(req_addr),
    .i_wdata(req_data),
    .o_busy(eng_busy),
    .o_done(eng_done),
    .o_rdata(eng_rdata),
    .o_fl_addr(O_FL_ADDR),
    .o_fl_dq(O_FL_DQ),
    .o_fl_dq_oe(O_FL_DQ_OE),
    .o_fl_ce_n(O_FL_CE_N),
    .o_fl_we_n(O_FL_WE_N),
    .o_fl_oe_n(O_FL_OE_N),
    .i_fl_dq(I_FL_DQ)
  );

  always @* begin
    rd_data = 32'h00000000;
    case (rd_addr)
      `OFS_CTRL: rd_data = {28'h0, op_r};
      `OFS_ADDR: rd_data = addr_r;
      `OFS_DATA: rd_data = data_r;
      `OFS_STATUS: rd_data = {16'h0, remaining_word_count_r,
        buf_active_r, 2'b00, ~state_r[0], mode_r};
      `OFS_RDATA: rd_data = {16'h0, rdata_r};
      `OFS_IRQ_STAT: rd_data = {28'h0, irq_stat_r};
      `OFS_IRQ_MASK: rd_data = {28'h0, irq_mask_r};
      default: rd_data = 32'h00000000;
    endcase
  end

  // bus cycle that the present state asks for
  always @* begin
    req_rd = 1'b0;
    req_addr = `A_UNLOCK1;
    req_data = `D_STATUS;
    case (state_r)
      S_CHKR, S_POLLR: req_rd = 1'b1;
      S_CMD: begin
        req_addr = seq_addr[idx_r];
        req_data = seq_data[idx_r];
      end
      S_RD: begin
        req_rd = 1'b1;
        req_addr = fl_a;
      end
      S_HANG: begin
        req_addr = `A_ANY;
        req_data = `D_RESET;
      end
      default: req_rd = 1'b0;
    endcase
  end

  // command sequence loaded at the start of an operation
  always @(posedge I_REF_CLK) begin
    if (start) begin
      seq_addr[0] <= `A_UNLOCK1;
      seq_data[0] <= `D_UNLOCK1;
      seq_addr[1] <= `A_UNLOCK2;
      seq_data[1] <= `D_UNLOCK2;
      seq_addr[2] <= `A_UNLOCK1;
      seq_data[2] <= `D_IDENT;
      seq_addr[3] <= fl_a;
      seq_data[3] <= data_r[15:0];
      case (wr_data[3:0])
        `OP_QUERY: begin
          seq_addr[0] <= `A_QUERY;
          seq_data[0] <= `D_QUERY;
        end
        `OP_RESET: begin
          seq_addr[0] <= `A_ANY;
          seq_data[0] <= `D_RESET;
        end
        `OP_STATUS: seq_data[0] <= `D_STATUS;
        `OP_SECURE: seq_data[2] <= `D_SECURE;
        `OP_WORD_PROG: seq_data[2] <= `D_WORD_PROG;
        `OP_BUF_START: begin
          seq_addr[2] <= fl_a;
          seq_data[2] <= `D_BUF_ENTER;
          seq_addr[3] <= fl_a;
          seq_data[3] <= wc_word;
        end
        `OP_BUF_WORD: begin
          seq_addr[0] <= fl_a;
          seq_data[0] <= data_r[15:0];
        end
        `OP_BUF_CONFIRM: begin
          seq_addr[0] <= fl_a;
          seq_data[0] <= `D_BUF_CONFIRM;
        end
        `OP_SEC_EXIT: begin
          seq_data[2] <= `D_EXIT_ENTRY;
          seq_addr[3] <= `A_ANY;
          seq_data[3] <= `D_EXIT;
        end
        default: seq_data[0] <= `D_UNLOCK1;
      endcase
    end
  end

  always @* begin
    irq_set = 4'h0;
    irq_set[`IRQ_REFUSED] = ctrl_wr & ~start;
    irq_set[`IRQ_DONE] = (state_r == S_FIN);
    irq_set[`IRQ_PROT] = (state_r == S_CHKR) & eng_done &
      eng_rdata[`SR_PROT_BIT];
    irq_set[`IRQ_HANG] = (state_r == S_HANG) & eng_done;
  end

  always @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_r <= S_IDLE;
      op_r <= 4'h0;
      mode_r <= M_READ;
      prev_mode_r <= M_READ;
      addr_r <= `RST_ADDR;
      data_r <= `RST_DATA;
      rdata_r <= 16'h0000;
      irq_stat_r <= 4'h0;
      irq_mask_r <= `RST_IRQ_MASK;
      issued_r <= 1'b0;
      go_r <= 1'b0;
      idx_r <= 2'b00;
      n_cyc_r <= 3'h0;
      need_chk_r <= 1'b0;
      need_rd_r <= 1'b0;
      need_poll_r <= 1'b0;
      buf_active_r <= 1'b0;
      entry_sector_addr_r <= 7'h00;
      remaining_word_count_r <= 8'h00;
    end else begin
      go_r <= 1'b0;
      // a new event wins over a same-cycle write-one-to-clear
      irq_stat_r <= (irq_stat_r & ~((wr & (wr_addr == `OFS_IRQ_STAT)) ?
        wr_data[3:0] & {4{wr_strb[0]}} : 4'h0)) | irq_set;
      if (wr & (wr_addr == `OFS_IRQ_MASK) & wr_strb[0]) begin
        irq_mask_r <= wr_data[3:0];
      end
      if (wr & (wr_addr == `OFS_ADDR) & state_r[0]) begin
        addr_r <= merge(addr_r, wr_data, wr_strb);
      end
      if (wr & (wr_addr == `OFS_DATA) & state_r[0]) begin
        data_r <= merge(data_r, wr_data, wr_strb);
      end
      if (~state_r[0] & ~state_r[8] & ~issued_r & ~eng_busy) begin
        go_r <= 1'b1;
        issued_r <= 1'b1;
      end
      if (eng_done) begin
        issued_r <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (start) begin
            op_r <= wr_data[3:0];
            idx_r <= 2'b00;
            need_chk_r <= 1'b0;
            need_rd_r <= 1'b0;
            need_poll_r <= 1'b0;
            n_cyc_r <= 3'h1;
            case (wr_data[3:0])
              `OP_READ: n_cyc_r <= 3'h0;
              `OP_IDENT, `OP_SECURE: n_cyc_r <= 3'h3;
              `OP_STATUS: need_rd_r <= 1'b1;
              `OP_WORD_PROG: begin
                n_cyc_r <= 3'h4;
                need_chk_r <= 1'b1;
                need_poll_r <= 1'b1;
              end
              `OP_BUF_START: begin
                n_cyc_r <= 3'h4;
                need_chk_r <= 1'b1;
              end
              `OP_BUF_CONFIRM: need_poll_r <= 1'b1;
              `OP_SEC_EXIT: n_cyc_r <= 3'h4;
              default: n_cyc_r <= 3'h1;
            endcase
            if (wr_data[3:0] == `OP_READ) begin
              state_r <= S_RD;
              need_rd_r <= 1'b1;
            end else if ((wr_data[3:0] == `OP_WORD_PROG) |
                (wr_data[3:0] == `OP_BUF_START)) begin
              state_r <= S_CHKW;
            end else begin
              state_r <= S_CMD;
            end
          end
        end
        S_CHKW: if (eng_done) state_r <= S_CHKR;
        S_CHKR: begin
          if (eng_done) begin
            rdata_r <= eng_rdata;
            // protected region: nothing beyond the status read
            state_r <= eng_rdata[`SR_PROT_BIT] ? S_IDLE : S_CMD;
          end
        end
        S_CMD: begin
          if (eng_done) begin
            idx_r <= idx_r + 2'b01;
            if ({1'b0, idx_r} + 3'h1 == n_cyc_r) begin
              state_r <= need_rd_r ? S_RD :
                need_poll_r ? S_POLLW : S_FIN;
            end
          end
        end
        S_RD: begin
          if (eng_done) begin
            rdata_r <= eng_rdata;
            state_r <= S_FIN;
          end
        end
        S_POLLW: if (eng_done) state_r <= S_POLLR;
        S_POLLR: begin
          if (eng_done) begin
            rdata_r <= eng_rdata;
            if (~eng_rdata[`SR_READY_BIT]) begin
              state_r <= S_POLLW;
            end else if (eng_rdata[`SR_PGM_ERR_BIT]) begin
              state_r <= S_HANG;
            end else begin
              state_r <= S_FIN;
            end
          end
        end
        S_HANG: if (eng_done) state_r <= S_FIN;
        S_FIN: begin
          state_r <= S_IDLE;
          case (op_r)
            `OP_QUERY, `OP_IDENT, `OP_SECURE: begin
              prev_mode_r <= mode_r;
              mode_r <= (op_r == `OP_QUERY) ? M_QUERY :
                (op_r == `OP_IDENT) ? M_IDENT : M_SECURE;
            end
            `OP_RESET: begin
              if (~buf_active_r) begin
                mode_r <= prev_mode_r;
                prev_mode_r <= M_READ;
              end
              buf_active_r <= 1'b0;
            end
            `OP_SEC_EXIT: begin
              mode_r <= prev_mode_r;
              prev_mode_r <= M_READ;
            end
            `OP_BUF_START: begin
              buf_active_r <= 1'b1;
              entry_sector_addr_r <= current_sector_addr;
              remaining_word_count_r <= wc_word[7:0];
            end
            `OP_BUF_WORD: remaining_word_count_r <=
              remaining_word_count_r - 8'h01;
            `OP_BUF_CONFIRM: buf_active_r <= 1'b0;
            default: mode_r <= mode_r;
          endcase
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule // flash_host_ctrl

// File: flash_host_ctrl_checker.sv
// Purpose: port checker of flash_host_ctrl
// Assumes: one clock domain, async high reset
// Notes: bound after the module
`timescale 1ns/1ps
module flash_host_ctrl_checker (
  input wire I_REF_CLK, I_SYS_RST, I_ARVALID, I_RREADY, I_BREADY,
  input wire O_ARREADY, O_RVALID, O_BVALID, O_FL_CE_N, O_FL_WE_N,
  input wire O_FL_OE_N, O_FL_DQ_OE,
  input wire [31:0] O_RDATA,
  input wire [21:0] O_FL_ADDR
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_bh; O_BVALID && !I_BREADY |=> O_BVALID; endproperty
  a_bh: assert property (p_bh) else $error("bvalid dropped");
  property p_rh; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_rh: assert property (p_rh) else $error("read data dropped");
  property p_ar; O_ARREADY == !O_RVALID; endproperty
  a_ar: assert property (p_ar) else $error("arready wrong");
  property p_ra; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
  a_ra: assert property (p_ra) else $error("no read answer");
  property p_wc; !O_FL_WE_N |-> !O_FL_CE_N && O_FL_DQ_OE && O_FL_OE_N;
  endproperty
  a_wc: assert property (p_wc) else $error("write strobe");
  property p_wp; $fell(O_FL_WE_N) |=> O_FL_WE_N; endproperty
  a_wp: assert property (p_wp) else $error("write pulse");
  property p_ws; $fell(O_FL_CE_N) && O_FL_DQ_OE |=> $fell(O_FL_WE_N);
  endproperty
  a_ws: assert property (p_ws) else $error("write start");
  property p_as; !O_FL_CE_N && !$past(O_FL_CE_N) |-> $stable(O_FL_ADDR);
  endproperty
  a_as: assert property (p_as) else $error("address moved");
  c_w: cover property ($fell(O_FL_WE_N));
  c_r: cover property (O_RVALID && I_RREADY);
  c_b: cover property (O_BVALID && I_BREADY);
endmodule // flash_host_ctrl_checker
bind flash_host_ctrl flash_host_ctrl_checker i_chk (.*);

// File: flash_dev_model.sv
// Purpose: behavioural flash device
// Assumes: commands latch on the rising write strobe
// Notes: released data lines show the inverted word
`timescale 1ns/1ps
module flash_dev_model (
  input wire [21:0] i_addr,
  input wire [15:0] i_dq,
  input wire i_ce_n, i_we_n, i_oe_n, i_prot,
  output wire [15:0] o_dq
);
  localparam RD = 3'd0, QRY = 3'd1, IDN = 3'd2, SEC = 3'd3, EXT = 3'd4;
  reg [2:0] st = RD;
  reg [2:0] prev = RD;
  reg [1:0] ul = 2'd0;
  reg stat = 1'b0;
  reg err = 1'b0;
  wire sw_rst = i_dq == 16'h00f0;
  wire [15:0] val = stat ? {11'h004, err, 1'b0, i_prot, 2'b00} :
    st == QRY ? 16'h0051 : st == IDN ? 16'h0001 :
    st == SEC ? {8'h5e, i_addr[7:0]} : i_addr[15:0];
  assign o_dq = (!i_ce_n && !i_oe_n) ? val : ~val;
  always @(posedge i_we_n) begin
    if (!i_ce_n) begin
      ul <= 2'd0;
      stat <= 1'b0;
      if (i_dq == 16'h00aa && i_addr == 22'h555) begin
        ul <= 2'd1;
      end else if (ul == 2'd1 && i_dq == 16'h0055 && i_addr == 22'h2aa) begin
        ul <= 2'd2;
      end else if (i_dq == 16'h0070 && i_addr == 22'h555) begin
        stat <= 1'b1;
      end else if (err) begin
        if (sw_rst) err <= 1'b0;
      end else if (i_dq == 16'hdead) begin
        err <= 1'b1; // this data word stands for a program timeout
      end else if (i_dq == 16'h0098) begin
        prev <= st;
        st <= QRY;
      end else if (st == QRY) begin
        if (sw_rst || i_dq == 16'h00ff) st <= prev;
      end else if (sw_rst || (st == EXT && i_dq == 16'h0000)) begin
        st <= RD;
      end else if (ul == 2'd2 && i_dq == 16'h0090) begin
        st <= st == RD ? IDN : EXT;
      end else if (ul == 2'd2 && i_dq == 16'h0088) begin
        st <= SEC;
      end
    end
  end
endmodule // flash_dev_model

// File: tb_flash_host_ctrl.sv
// Purpose: bench of flash_host_ctrl
// Assumes: behavioural flash on the far side
// Notes: bench signals carry the port names
`timescale 1ns/1ps
`include "flash_host_regs.vh"
module tb_flash_host_ctrl;
  logic I_REF_CLK = 1'b0, I_SYS_RST = 1'b1, prot = 1'b0;
  logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0, r;
  logic [3:0] I_WSTRB = 4'hf;
  logic I_AWVALID = 1'b0, I_WVALID = 1'b0, I_BREADY = 1'b0;
  logic I_ARVALID = 1'b0, I_RREADY = 1'b0;
  wire [31:0] O_RDATA;
  wire [21:0] O_FL_ADDR;
  wire [15:0] O_FL_DQ, I_FL_DQ;
  wire [1:0] O_BRESP, O_RRESP;
  wire O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_FL_DQ_OE;
  wire O_FL_CE_N, O_FL_WE_N, O_FL_OE_N, O_IRQ;
  int fail_count = 0, checks_done = 0;
  flash_host_ctrl i_dut (.*);
  flash_dev_model i_dev (.i_addr(O_FL_ADDR), .i_dq(O_FL_DQ),
    .i_ce_n(O_FL_CE_N), .i_we_n(O_FL_WE_N), .i_oe_n(O_FL_OE_N),
    .i_prot(prot), .o_dq(I_FL_DQ));
  initial forever #25 I_REF_CLK = ~I_REF_CLK;
  task automatic chk(input logic [31:0] got, exp, input string nm);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w, b, v;
    b = 0;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    while (!b) begin
      @(negedge I_REF_CLK);
      aw = I_AWVALID && O_AWREADY;
      w = I_WVALID && O_WREADY;
      v = O_BVALID;
      b = v && I_BREADY;
      @(posedge I_REF_CLK);
      if (aw) I_AWVALID <= 1'b0;
      if (w) I_WVALID <= 1'b0;
      I_BREADY <= v && !b;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bit ar, v, t;
    t = 0;
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    while (!t) begin
      @(negedge I_REF_CLK);
      ar = I_ARVALID && O_ARREADY;
      v = O_RVALID;
      t = v && I_RREADY;
      d = O_RDATA;
      @(posedge I_REF_CLK);
      if (ar) I_ARVALID <= 1'b0;
      I_RREADY <= v && !t;
    end
  endtask
  // clears pending events, starts one op and waits until idle
  task automatic op(input logic [3:0] o);
    wr(`OFS_IRQ_STAT, 32'hf);
    wr(`OFS_CTRL, {28'h0, o});
    r = 32'h10;
    while (r[4]) rd(`OFS_STATUS, r);
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] m, e,
    input string nm);
    rd(a, r);
    chk(r & m, e, nm);
    chk({28'h0, O_RRESP, O_BRESP}, 32'h0, "resp");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge I_REF_CLK);
    I_SYS_RST <= 1'b0;
    @(posedge I_REF_CLK);
    ck(`OFS_STATUS, 32'hf, 32'h1, "mode");
    wr(`OFS_IRQ_MASK, 32'h2);
    wr(`OFS_ADDR, 32'h123);
    op(`OP_QUERY);
    op(`OP_READ);
    ck(`OFS_RDATA, 32'hffff, 32'h51, "query");
    op(`OP_IDENT);
    chk({31'h0, O_IRQ}, 32'h1, "irq");
    wr(`OFS_IRQ_STAT, 32'h2);
    chk({31'h0, O_IRQ}, 32'h0, "irq");
    op(`OP_RESET);
    op(`OP_IDENT);
    op(`OP_READ);
    ck(`OFS_RDATA, 32'hffff, 32'h1, "ident");
    op(`OP_RESET);
    ck(`OFS_STATUS, 32'hf, 32'h1, "mode");
    op(`OP_SECURE);
    op(`OP_READ);
    ck(`OFS_RDATA, 32'hffff, 32'h5e23, "secure");
    op(`OP_STATUS);
    ck(`OFS_RDATA, 32'hffff, 32'h80, "status");
    wr(`OFS_DATA, 32'h1234);
    op(`OP_WORD_PROG);
    ck(`OFS_IRQ_STAT, 32'hf, 32'h1, "done");
    chk({31'h0, O_IRQ}, 32'h0, "masked");
    wr(`OFS_DATA, 32'd129);
    op(`OP_BUF_START);
    ck(`OFS_IRQ_STAT, 32'hf, 32'h2, "count");
    wr(`OFS_DATA, 32'd2);
    op(`OP_BUF_START);
    ck(`OFS_STATUS, 32'hff8f, 32'h188, "load");
    op(`OP_BUF_WORD);
    ck(`OFS_STATUS, 32'hff00, 32'h0, "left");
    wr(`OFS_ADDR, 32'h8123);
    op(`OP_BUF_WORD);
    ck(`OFS_IRQ_STAT, 32'hf, 32'h2, "sector");
    wr(`OFS_ADDR, 32'h123);
    op(`OP_BUF_WORD);
    ck(`OFS_STATUS, 32'hff00, 32'hff00, "left");
    op(`OP_BUF_CONFIRM);
    ck(`OFS_STATUS, 32'h8f, 32'h8, "mode");
    wr(`OFS_DATA, 32'hdead);
    op(`OP_WORD_PROG);
    ck(`OFS_IRQ_STAT, 32'hf, 32'h9, "hang");
    ck(`OFS_STATUS, 32'h9f, 32'h8, "mode");
    op(`OP_SEC_EXIT);
    ck(`OFS_STATUS, 32'hf, 32'h1, "mode");
    prot <= 1'b1;
    op(`OP_SECURE);
    op(`OP_WORD_PROG);
    ck(`OFS_IRQ_STAT, 32'h5, 32'h4, "protect");
    final_report;
  end
  initial begin
    repeat (40000) @(posedge I_REF_CLK);
    fail_count++;
    final_report;
  end
endmodule // tb_flash_host_ctrl
